// >>> include/spi_diag_pkg.sv
// Constants shared by the serial slave port and its register memory
package spi_diag_pkg;
	localparam int          CLK_MHZ          = 200;
	localparam int          FILTER_NS        = 10000;
	localparam int          FILTER_CYC       = (FILTER_NS * CLK_MHZ + 999) / 1000;
	localparam int          STARTUP_NS       = 20000;
	localparam int          STARTUP_CYC      = (STARTUP_NS * CLK_MHZ + 999) / 1000;
	localparam int          STARTUP_ERR_NS   = 40000;
	localparam int          STARTUP_ERR_CYC  = (STARTUP_ERR_NS * CLK_MHZ + 999) / 1000;
	localparam int          FRAME_BITS       = 16;
	localparam logic [3:0]  FRAME_LAST       = 4'hf;
	localparam logic [6:0]  ADDR_STATUS      = 7'h0f;
	localparam logic [6:0]  CTRL_LAST        = 7'h1f;
	localparam logic [6:0]  ADDR_CNT_LO      = 7'h41;
	localparam logic [6:0]  ADDR_CNT_HI      = 7'h42;
	localparam logic [6:0]  ADDR_VBAT        = 7'h45;
	localparam logic [6:0]  ADDR_TJ          = 7'h46;
	localparam logic [7:0]  ZERO_BYTE        = 8'h00;
	localparam int          BIT_REGULATED    = 7;
	localparam int          BIT_RESERVED     = 6;
	localparam int          BIT_GATE_GOOD    = 5;
	localparam int          BIT_OVERTEMP     = 4;
	localparam int          BIT_UNDER        = 3;
	localparam int          BIT_OVER         = 2;
	localparam int          BIT_CMD_ERR      = 1;
	localparam int          BIT_GATE_FAULT   = 0;
	localparam int          CMD_RW_BIT       = 15;
	localparam int          ADDR_MSB         = 14;
	localparam int          ADDR_LSB         = 8;
	typedef enum logic [1:0] {ACC_NONE, ACC_RW, ACC_RO} access_t;
endpackage : spi_diag_pkg

// >>> testbench/spi_master_model.sv
// Serial bus master model for the slave port
`timescale 1ns/1ps
`default_nettype none
module spi_master_model
(
	output logic      chip_select_n_out,
	output logic      sclk_out,
	output logic      sdi_out,
	input  wire logic sdo_in
);
	initial
	begin
		chip_select_n_out = 1'b1;
		sclk_out = 1'b0;
		sdi_out = 1'b0;
	end
	task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx);
		rx = '0;
		// Called on a falling system clock edge; 60/65 ns phases keep every change on one
		chip_select_n_out = 1'b0;
		#65;
		for (int i = n - 1; i >= 0; i--)
		begin
			sclk_out = 1'b1;
			sdi_out = tx[i];
			#60;
			sclk_out = 1'b0;
			rx = {rx[62:0], sdo_in};
			#65;
		end
		chip_select_n_out = 1'b1;
		sdi_out = ~sdi_out;
		#125;
	endtask : xfer
endmodule : spi_master_model
`default_nettype wire

// >>> testbench/spi_slave_diag_status_sva.sv
// Assertions on the serial slave port and gate halt outputs
`timescale 1ns/1ps
`default_nettype none
module spi_slave_diag_status_sva
(
	input wire logic       clk_in,
	input wire logic       rst_in,
	input wire logic       chip_select_n_in,
	input wire logic       sclk_in,
	input wire logic       sdi_in,
	input wire logic       off_mode_in,
	input wire logic       output_in_window_in,
	input wire logic       gate_supply_in_window_in,
	input wire logic       overtemp_in,
	input wire logic       supply_under_in,
	input wire logic       supply_over_in,
	input wire logic       gate_pwm_in,
	input wire logic [7:0] vbat_in,
	input wire logic [7:0] tj_in,
	input wire logic       sdo_out,
	input wire logic       sdo_oe_n_out,
	input wire logic       gate_out,
	input wire logic       halted_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	sequence cs_idle;
		chip_select_n_in[*6];
	endsequence
	sequence clk_high_settled;
		(!chip_select_n_in && sclk_in)[*8];
	endsequence
	sequence off_quiet;
		!off_mode_in[*6];
	endsequence
	a_idle_float: assert property (cs_idle |-> sdo_oe_n_out)
		else $error("serial output driven while deselected");
	a_frame_drive: assert property ((!chip_select_n_in)[*6] |-> !sdo_oe_n_out)
		else $error("serial output floating inside a frame");
	a_sdo_settled: assert property (clk_high_settled |-> $stable(sdo_out))
		else $error("serial output moved late in the high phase");
	a_gate_pwm: assert property (gate_out |-> $past(gate_pwm_in))
		else $error("gate high without drive request");
	a_halt_gate: assert property (halted_out |=> !gate_out)
		else $error("gate toggles while halted");
	a_halt_overtemp: assert property (overtemp_in |-> ##[1:4] halted_out)
		else $error("overtemperature did not halt");
	a_halt_under: assert property (supply_under_in |-> ##[1:4] halted_out)
		else $error("undervoltage did not halt");
	a_halt_over: assert property (supply_over_in |-> ##[1:4] halted_out)
		else $error("overvoltage did not halt");
	a_halt_sticky: assert property (off_quiet ##0 halted_out |=> halted_out)
		else $error("halt released without off mode");
endmodule : spi_slave_diag_status_sva
`default_nettype wire

// >>> testbench/testbench.sv
// Self-checking bench for the serial slave port
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk_in, rst_in, off_mode_in, output_in_window_in, gate_supply_in_window_in, gate_pwm_in;
	logic [2:0]  flt;
	logic [7:0]  vbat_in, tj_in, exp_d;
	logic [7:0]  mem [32];
	logic [31:0] seed, written;
	logic [31:0] pwm_seed = 32'hd707a8f4;
	logic [63:0] rsp;
	logic        err_e, skip;
	int          mismatches, check_count, cyc;
	wire         sdo_out, sdo_oe_n_out, gate_out, halted_out, chip_select_n_in, sclk_in, sdi_in;
	wire         sdo_pin = sdo_oe_n_out ? 1'bz : sdo_out;
	spi_master_model u_spi_master_model (.chip_select_n_out(chip_select_n_in), .sclk_out(sclk_in),
		.sdi_out(sdi_in), .sdo_in(sdo_pin));
	spi_slave_diag_status u_spi_slave_diag_status (.clk_in, .rst_in, .chip_select_n_in, .sclk_in, .sdi_in,
		.off_mode_in, .output_in_window_in, .gate_supply_in_window_in, .overtemp_in(flt[2]),
		.supply_under_in(flt[1]), .supply_over_in(flt[0]), .gate_pwm_in, .vbat_in, .tj_in, .sdo_out,
		.sdo_oe_n_out, .gate_out, .halted_out);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic bad_acc(input logic rw, input logic [6:0] a);
		return a > spi_diag_pkg::CTRL_LAST && !(rw && a inside {7'h41, 7'h42, 7'h45, 7'h46});
	endfunction : bad_acc
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic final_report;
		$display("mismatches=%0d checks=%0d", mismatches, check_count);
		if (mismatches == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report
	// Runs one frame and advances the expected reply
	task automatic cmd(input int n, input logic [15:0] pre, input logic rw, input logic [6:0] a, input logic [7:0] d);
		u_spi_master_model.xfer(n, {32'h0, pre, rw, a, d}, rsp);
		if (!skip) chk(rsp[n-16 +: 8], exp_d);
		chk(rsp[n-8 +: 8] & 8'h42, {6'h0, err_e, 1'b0});
		if (n > 16) chk(rsp[15:8], pre[15:8]);
		if (n > 16) chk(rsp[7:0], pre[7:0]);
		skip = 1'b0;
		if (bad_acc(rw, a))
		begin
			exp_d = 8'h00;
			err_e = 1'b1;
		end
		else if (a == spi_diag_pkg::ADDR_STATUS)
		begin
			skip = 1'b1;
			if (!rw) err_e = 1'b0;
		end
		else if (a <= spi_diag_pkg::CTRL_LAST)
		begin
			if (!rw) mem[a[4:0]] = d;
			if (!rw) written[a[4:0]] = 1'b1;
			exp_d = mem[a[4:0]];
			skip = !written[a[4:0]];
		end
		else
		begin
			exp_d = (a == spi_diag_pkg::ADDR_VBAT) ? vbat_in : tj_in;
			skip = !(a inside {spi_diag_pkg::ADDR_VBAT, spi_diag_pkg::ADDR_TJ});
		end
	endtask : cmd
	initial
	begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			mismatches++;
			final_report();
		end
	end
	always @(negedge clk_in)
	begin
		pwm_seed    <= lfsr(pwm_seed);
		gate_pwm_in <= pwm_seed[3];
	end
	initial
	begin
		{rst_in, output_in_window_in, gate_supply_in_window_in} = 3'h7;
		{off_mode_in, flt, err_e, skip, exp_d, written} = '0;
		{mismatches, check_count, cyc} = '0;
		{vbat_in, tj_in, seed} = {16'h5a3c, 32'hd707a8f4};
		repeat (6) @(posedge clk_in);
		@(negedge clk_in) rst_in = 1'b0;
		repeat (5000) @(negedge clk_in);
		cmd(16, 16'h0, 1'b0, spi_diag_pkg::ADDR_STATUS, 8'h00);
		cmd(16, 16'h0, 1'b0, 7'h03, 8'ha5);
		chk(rsp[15:8] & 8'ha0, 8'ha0);
		for (int i = 0; i < 8; i++)
		begin
			@(negedge clk_in);
			chk({7'h0, gate_out}, {7'h0, gate_pwm_in});
		end
		for (int i = 0; i < 16; i++)
		begin
			seed = lfsr(seed);
			cmd(16, 16'h0, seed[5], {2'b0, seed[4:0]}, seed[15:8]);
		end
		for (int i = 0; i < 3; i++)
		begin
			seed = lfsr(seed);
			{vbat_in, tj_in} = seed[15:0];
			cmd(16, 16'h0, 1'b1, spi_diag_pkg::ADDR_VBAT, seed[23:16]);
			cmd(16, 16'h0, 1'b1, spi_diag_pkg::ADDR_TJ, seed[31:24]);
		end
		cmd(16, 16'h0, 1'b0, 7'h03, 8'h5a);
		cmd(16, 16'h0, 1'b0, spi_diag_pkg::ADDR_VBAT, 8'h11);
		cmd(16, 16'h0, 1'b1, 7'h30, 8'h00);
		cmd(16, 16'h0, 1'b0, 7'h60, 8'h22);
		cmd(16, 16'h0, 1'b0, spi_diag_pkg::ADDR_STATUS, 8'h00);
		cmd(16, 16'h0, 1'b1, 7'h03, 8'h00);
		u_spi_master_model.xfer(15, {49'h0, 7'h03, 8'hee}, rsp);
		chk({1'b0, rsp[6:0]}, {1'b0, exp_d[7:1]});
		{exp_d, err_e, skip} = 10'h002;
		cmd(16, 16'h0, 1'b1, 7'h03, 8'h00);
		cmd(16, 16'h0, 1'b1, 7'h03, 8'h00);
		cmd(32, 16'hc3a5, 1'b0, 7'h07, 8'h3c);
		cmd(16, 16'h0, 1'b1, 7'h07, 8'h00);
		for (int k = 0; k < 3; k++)
		begin
			@(negedge clk_in) flt[k] = 1'b1;
			repeat (4) @(negedge clk_in);
			flt[k] = 1'b0;
			chk({7'h0, halted_out}, 8'h01);
			chk({7'h0, gate_out}, 8'h00);
			cmd(16, 16'h0, 1'b1, 7'h03, 8'h00);
			chk(rsp[15:8] & 8'h1c, 8'h04 << k);
			cmd(16, 16'h0, 1'b0, spi_diag_pkg::ADDR_STATUS, 8'h00);
			cmd(16, 16'h0, 1'b1, 7'h03, 8'h00);
			chk(rsp[15:8] & 8'h1c, 8'h00);
			chk({7'h0, halted_out}, 8'h01);
		end
		cmd(16, 16'h0, 1'b0, 7'h60, 8'h00);
		@(negedge clk_in) off_mode_in = 1'b1;
		repeat (10) @(negedge clk_in);
		off_mode_in = 1'b0;
		repeat (10) @(negedge clk_in);
		{exp_d, err_e, skip, written} = '0;
		cmd(16, 16'h0, 1'b1, 7'h03, 8'h00);
		chk(rsp[15:8] & 8'h1f, 8'h00);
		{output_in_window_in, gate_supply_in_window_in} = 2'b00;
		repeat (8100) @(negedge clk_in);
		cmd(16, 16'h0, 1'b1, 7'h03, 8'h00);
		chk(rsp[15:8] & 8'ha0, 8'h00);
		chk(rsp[15:8] & 8'h01, 8'h01);
		chk({7'h0, halted_out}, 8'h01);
		final_report();
	end
endmodule : testbench
bind spi_slave_diag_status spi_slave_diag_status_sva u_sva (.clk_in, .rst_in, .chip_select_n_in, .sclk_in,
	.sdi_in, .off_mode_in, .output_in_window_in, .gate_supply_in_window_in, .overtemp_in, .supply_under_in,
	.supply_over_in, .gate_pwm_in, .vbat_in, .tj_in, .sdo_out, .sdo_oe_n_out, .gate_out, .halted_out);
`default_nettype wire

// >>> verilog/reg_mem.sv
// Byte register memory for the 32 control registers, registered read
`timescale 1ns/1ps
`default_nettype none
module reg_mem
(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       wr_en_in,
	input  wire logic [4:0] wr_addr_in,
	input  wire logic [7:0] wr_data_in,
	input  wire logic [4:0] rd_addr_in,
	output logic      [7:0] rd_data_out
);
	logic [7:0] mem_reg [32];

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			for (int i = 0; i < 32; i++)
				mem_reg[i] <= spi_diag_pkg::ZERO_BYTE;
			rd_data_out <= spi_diag_pkg::ZERO_BYTE;
		end
		else
		begin
			if (wr_en_in)
				mem_reg[wr_addr_in] <= wr_data_in;
			rd_data_out <= mem_reg[rd_addr_in];
		end
	end
endmodule : reg_mem
`default_nettype wire

// >>> verilog/spi_slave_diag_status.sv
// Serial slave port with diagnostic status byte and gate halt control
// What this block does
// - Regulated bit follows filtered output window
// - Status bit 6 always reads zero
// - Gate supply good enables gate pin
// - Gate supply lost after startup halts output
// - Overtemp sets flag, halts; write/off clears
// - Undervoltage sets flag, halts; write/off clears
// - Overvoltage sets flag, halts; write/off clears
// - Rejected command sets command error flag
// - Gate supply start timeout sets fault, halts
// - Select low active; output floats when high
// - Sample on falling, shift on rising
// - Reply status byte then previous data
// - First command after off answers zero
// - Accept any multiple of sixteen clocks
// - Read ignores data, changes nothing
// - Non-multiple clock count rejects, flags error
// - Bad address or read-only write errs
// - Error changes nothing; next data zero
// - 128 addresses, control then diagnostic
// - Halt stops gate toggling
`timescale 1ns/1ps
`default_nettype none
module spi_slave_diag_status
(
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	input  wire logic       chip_select_n_in,
	input  wire logic       sclk_in,
	input  wire logic       sdi_in,
	input  wire logic       off_mode_in,
	input  wire logic       output_in_window_in,
	input  wire logic       gate_supply_in_window_in,
	input  wire logic       overtemp_in,
	input  wire logic       supply_under_in,
	input  wire logic       supply_over_in,
	input  wire logic       gate_pwm_in,
	input  wire logic [7:0] vbat_in,
	input  wire logic [7:0] tj_in,
	output logic            sdo_out,
	output logic            sdo_oe_n_out,
	output logic            gate_out,
	output logic            halted_out
);
	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [2:0] s1_reg;
	logic [2:0] s2_reg;
	logic [2:0] sd_reg;
	logic [5:0] a1_reg;
	logic [5:0] a2_reg;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			// Idle pin levels: select high, clock and data low, so no false edge follows reset
			s1_reg <= 3'h4;
			s2_reg <= 3'h4;
			sd_reg <= 3'h4;
			a1_reg <= 6'h00;
			a2_reg <= 6'h00;
		end
		else
		begin
			s1_reg <= {chip_select_n_in, sclk_in, sdi_in};
			s2_reg <= s1_reg;
			sd_reg <= s2_reg;
			a1_reg <= {off_mode_in, output_in_window_in, gate_supply_in_window_in,
				overtemp_in, supply_under_in, supply_over_in};
			a2_reg <= a1_reg;
		end
	end

	wire cs_n     = s2_reg[2];
	wire sclk     = s2_reg[1];
	wire sdi      = s2_reg[0];
	wire cs_fall  = sd_reg[2] & ~cs_n;
	wire cs_rise  = ~sd_reg[2] & cs_n;
	wire sclk_rise = ~sd_reg[1] & sclk & ~cs_n;
	wire sclk_fall = sd_reg[1] & ~sclk & ~cs_n;
	wire off_mode = a2_reg[5];
	wire out_win  = a2_reg[4];
	wire gs_win   = a2_reg[3];
	wire ot_ev    = a2_reg[2];
	wire uv_ev    = a2_reg[1];
	wire ov_ev    = a2_reg[0];

	// ----------------------------------------
	// Supervision timers and status flags
	// ----------------------------------------
	logic [15:0] filt_reg;
	logic [15:0] start_reg;
	logic        regulated_reg;
	logic        gate_good_reg;
	logic [4:0]  err_reg;
	logic        halted_reg;
	logic        off_d_reg;
	logic        first_reg;

	wire startup_done = start_reg >= 16'(spi_diag_pkg::STARTUP_CYC);
	wire startup_err  = start_reg >= 16'(spi_diag_pkg::STARTUP_ERR_CYC);
	wire filt_done    = filt_reg >= 16'(spi_diag_pkg::FILTER_CYC);
	wire gs_lost      = startup_done & gate_good_reg & ~gs_win;
	wire gs_timeout   = startup_err & ~gate_good_reg & ~gs_win;
	wire cmd_err_ev;
	wire status_wr;
	wire clr_flags    = status_wr | off_mode;
	// Flag order: overtemp, under, over, cmd error, gate fault
	wire [4:0] set_ev = {ot_ev, uv_ev, ov_ev, cmd_err_ev, gs_timeout};
	wire [7:0] status_byte = {regulated_reg, 1'b0, gate_good_reg, err_reg};

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			filt_reg      <= 16'h0000;
			start_reg     <= 16'h0000;
			regulated_reg <= 1'b0;
			gate_good_reg <= 1'b0;
			err_reg       <= 5'h00;
			halted_reg    <= 1'b0;
			off_d_reg     <= 1'b1;
			first_reg     <= 1'b1;
		end
		else
		begin
			off_d_reg <= off_mode;
			if (out_win == regulated_reg || filt_done)
				filt_reg <= 16'h0000;
			else
				filt_reg <= filt_reg + 16'h0001;
			if (filt_done)
				regulated_reg <= out_win;
			if (off_mode)
				start_reg <= 16'h0000;
			else if (!startup_err)
				start_reg <= start_reg + 16'h0001;
			if (off_mode || gs_lost)
				gate_good_reg <= 1'b0;
			else if (gs_win && !halted_reg)
				gate_good_reg <= 1'b1;
			err_reg <= set_ev | (clr_flags ? 5'h00 : err_reg);
			if (off_mode)
				halted_reg <= 1'b0;
			else if (ot_ev || uv_ev || ov_ev || gs_timeout || gs_lost)
				halted_reg <= 1'b1;
			if (off_mode)
				first_reg <= 1'b1;
			else if (cs_rise)
				first_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Serial shifter
	// ----------------------------------------
	logic [15:0] rx_reg;
	logic [15:0] tx_reg;
	logic [3:0]  bit_reg;
	logic        wrapped_reg;
	logic [7:0]  reply_reg;
	logic        reply_zero_reg;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rx_reg      <= 16'h0000;
			tx_reg      <= 16'h0000;
			bit_reg     <= 4'h0;
			wrapped_reg <= 1'b0;
		end
		else if (cs_fall)
		begin
			bit_reg     <= 4'h0;
			wrapped_reg <= 1'b0;
			tx_reg      <= {status_byte, reply_zero_reg ? spi_diag_pkg::ZERO_BYTE : reply_reg};
		end
		else
		begin
			if (sclk_fall)
			begin
				rx_reg  <= {rx_reg[14:0], sdi};
				bit_reg <= bit_reg + 4'h1;
				if (bit_reg == spi_diag_pkg::FRAME_LAST)
					wrapped_reg <= 1'b1;
			end
			// Earlier received bits leave on the output for the next device
			if (sclk_rise && (bit_reg != 4'h0 || wrapped_reg))
				tx_reg <= {tx_reg[14:0], rx_reg[0]};
		end
	end

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	wire        cmd_read  = rx_reg[spi_diag_pkg::CMD_RW_BIT];
	wire [6:0]  cmd_addr  = rx_reg[spi_diag_pkg::ADDR_MSB:spi_diag_pkg::ADDR_LSB];
	wire [7:0]  cmd_data  = rx_reg[7:0];
	wire        len_ok    = (bit_reg == 4'h0) & wrapped_reg;

	function automatic spi_diag_pkg::access_t access_of(input logic [6:0] a);
		if (a <= spi_diag_pkg::CTRL_LAST)
			return (a == spi_diag_pkg::ADDR_STATUS) ? spi_diag_pkg::ACC_RW : spi_diag_pkg::ACC_RW;
		else if (a == spi_diag_pkg::ADDR_CNT_LO || a == spi_diag_pkg::ADDR_CNT_HI ||
			a == spi_diag_pkg::ADDR_VBAT || a == spi_diag_pkg::ADDR_TJ)
			return spi_diag_pkg::ACC_RO;
		else
			return spi_diag_pkg::ACC_NONE;
	endfunction : access_of

	wire spi_diag_pkg::access_t acc = access_of(cmd_addr);
	wire addr_bad  = (acc == spi_diag_pkg::ACC_NONE) |
		(~cmd_read & (acc == spi_diag_pkg::ACC_RO));
	wire frame_end = cs_rise & ~first_reg;
	assign cmd_err_ev = cs_rise & (~len_ok | addr_bad);
	wire cmd_ok    = cs_rise & len_ok & ~addr_bad;
	wire do_write  = cmd_ok & ~cmd_read;
	assign status_wr = do_write & (cmd_addr == spi_diag_pkg::ADDR_STATUS);
	wire mem_wr    = do_write & (cmd_addr != spi_diag_pkg::ADDR_STATUS);

	// ----------------------------------------
	// Register storage and read back
	// ----------------------------------------
	logic [7:0] mem_rd;
	logic       load_reg;
	logic [6:0] addr_hold_reg;
	logic       wr_hold_reg;
	logic [7:0] wdata_hold_reg;

	reg_mem u_mem
	(
		.clk_in      (clk_in),
		.rst_in      (rst_in),
		.wr_en_in    (mem_wr),
		.wr_addr_in  (cmd_addr[4:0]),
		.wr_data_in  (cmd_data),
		.rd_addr_in  (cmd_addr[4:0]),
		.rd_data_out (mem_rd)
	);

	wire [7:0] diag_val =
		(addr_hold_reg == spi_diag_pkg::ADDR_VBAT) ? vbat_in :
		(addr_hold_reg == spi_diag_pkg::ADDR_TJ)   ? tj_in   : spi_diag_pkg::ZERO_BYTE;
	wire [7:0] ctrl_val =
		(addr_hold_reg == spi_diag_pkg::ADDR_STATUS) ? status_byte :
		wr_hold_reg ? wdata_hold_reg : mem_rd;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			load_reg       <= 1'b0;
			addr_hold_reg  <= 7'h00;
			wr_hold_reg    <= 1'b0;
			wdata_hold_reg <= spi_diag_pkg::ZERO_BYTE;
			reply_reg      <= spi_diag_pkg::ZERO_BYTE;
			reply_zero_reg <= 1'b1;
		end
		else
		begin
			load_reg <= cmd_ok;
			if (cs_rise)
			begin
				addr_hold_reg  <= cmd_addr;
				wr_hold_reg    <= ~cmd_read;
				wdata_hold_reg <= cmd_data;
				reply_zero_reg <= ~cmd_ok | first_reg;
			end
			if (off_mode)
				reply_zero_reg <= 1'b1;
			else if (load_reg && frame_end == 1'b0)
				reply_reg <= (addr_hold_reg <= spi_diag_pkg::CTRL_LAST) ? ctrl_val : diag_val;
		end
	end

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sdo_out      <= 1'b0;
			sdo_oe_n_out <= 1'b1;
			gate_out     <= 1'b0;
			halted_out   <= 1'b0;
		end
		else
		begin
			sdo_out      <= tx_reg[15];
			sdo_oe_n_out <= cs_n;
			gate_out     <= gate_pwm_in & gate_good_reg & ~halted_reg;
			halted_out   <= halted_reg;
		end
	end
endmodule : spi_slave_diag_status
`default_nettype wire
